// *** logic/meep_builder.sv ***
// Purpose: Builds event packets for the third and fourth kinds of mirror failure
// Assumes: Event requests are one-cycle pulses with the acquisition time beside them
// Notes: Packets leave through an 8-word FIFO, one byte per accepted transfer
//
// Overview of operation
// - The first header bits are version 000, type 0, data field header flag 1, then the process identifier.
// - The process identifier 1000111 and packet category 7 follow the version bits.
// - A 14-bit sequence count starts at zero and rises by one per packet for this identifier.
// - The packet length field is the source data size plus nine, which is always 11.
// - A 48-bit time of acquisition start follows, four bytes seconds then two bytes fraction.
// - The secondary header opens with service version 010, checksum 0, four spare zeros.
// - The service type field is 00000101 in every packet of both kinds.
// - The third-kind packet carries event identifier 43003 for the recovered failure.
// - The third-kind packet carries service subtype 00000010.
// - The fourth-kind packet is sent when the space position is still not found.
// - The fourth-kind packet carries service subtype 00000011.
// - The source data after the pad byte is exactly two bytes, the event identifier only.
// - The fourth-kind packet carries event identifier 43004.
`timescale 1ns/1ps
`default_nettype none
module meep_builder
	import meep_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic third_event_i,
	input wire logic fourth_event_i,
	input wire logic [31:0] time_seconds_i,
	input wire logic [15:0] time_fraction_i,
	output logic [7:0] out_data_o,
	output logic out_last_o,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic busy_o,
	output logic [13:0] source_sequence_count_field_o
);

	// ********************************************************
	// State
	// ********************************************************
	typedef struct packed {
		meep_state_type state;
		meep_kind_type kind;
		logic [4:0] idx;
		logic [13:0] seq;
		logic [47:0] stamp;
		logic pend_third;
		logic pend_fourth;
		logic [47:0] stamp_third;
		logic [47:0] stamp_fourth;
		logic busy;
	} meep_bld_state_type;

	meep_bld_state_type r, n;
	logic wr_valid;
	logic wr_ready;
	logic wr_fire;
	logic [7:0] wr_byte;
	logic wr_last;
	logic [8:0] fifo_out;
	logic fifo_valid;

	// ********************************************************
	// Packet byte table
	// ********************************************************
	// One function builds every byte of the stream; the checks compare it with fixed values or with the stored count and time
	function automatic logic [7:0] pkt_byte(
		input logic [4:0] idx,
		input meep_kind_type kind,
		input logic [13:0] seq,
		input logic [47:0] stamp
	);
		logic [15:0] ident;
		logic [15:0] seqw;
		logic [15:0] len;
		logic [15:0] eid;
		logic [2:0] tsel;
		logic [7:0] b;
		ident = {VERSION_VAL, TYPE_VAL, DFH_FLAG_VAL, APPLICATION_PROCESS_IDENTIFIER, CATEGORY_VAL};
		seqw = {SEGMENT_FLAGS_VAL, seq};
		len = SOURCE_DATA_BYTES + LENGTH_OFFSET;
		eid = (kind == KIND_THIRD) ? EVENT_ID_THIRD : EVENT_ID_FOURTH;
		tsel = 3'(IDX_TIME_LAST - idx);
		b = PAD_BYTE_VAL;
		if (idx == IDX_FIRST) begin
			b = ident[15:8];
		end else if (idx == IDX_ID_LO) begin
			b = ident[7:0];
		end else if (idx == IDX_SEQ_HI) begin
			b = seqw[15:8];
		end else if (idx == IDX_SEQ_LO) begin
			b = seqw[7:0];
		end else if (idx == IDX_LEN_HI) begin
			b = len[15:8];
		end else if (idx == IDX_LEN_LO) begin
			b = len[7:0];
		end else if (idx >= IDX_TIME_FIRST && idx <= IDX_TIME_LAST) begin
			b = 8'(stamp >> {tsel, 3'h0});
		end else if (idx == IDX_SVC_VER) begin
			b = {SERVICE_VERSION_VAL, CHECKSUM_FLAG_VAL, SPARE_VAL};
		end else if (idx == IDX_SVC_TYPE) begin
			b = SERVICE_TYPE_EVENT;
		end else if (idx == IDX_SVC_SUB) begin
			b = (kind == KIND_THIRD) ? SUBTYPE_WARNING : SUBTYPE_GROUND_ACTION;
		end else if (idx == IDX_PAD) begin
			b = PAD_BYTE_VAL;
		end else if (idx == IDX_EID_HI) begin
			b = eid[15:8];
		end else if (idx == IDX_LAST) begin
			b = eid[7:0];
		end
		return b;
	endfunction

	// ********************************************************
	// Sequencing
	// ********************************************************
	// Pending flags are set after the clear, so a request in the start cycle is kept
	always_comb begin
		n = r;
		wr_valid = (r.state == ST_EMIT);
		wr_byte = pkt_byte(r.idx, r.kind, r.seq, r.stamp);
		wr_last = (r.idx == IDX_LAST);
		wr_fire = wr_valid && wr_ready;
		unique case (r.state)
			ST_IDLE: begin
				// Third kind first when both wait; it reports the earlier outcome
				if (r.pend_third) begin
					n.state = ST_EMIT;
					n.kind = KIND_THIRD;
					n.stamp = r.stamp_third;
					n.idx = IDX_FIRST;
					n.pend_third = 1'b0;
				end else if (r.pend_fourth) begin
					n.state = ST_EMIT;
					n.kind = KIND_FOURTH;
					n.stamp = r.stamp_fourth;
					n.idx = IDX_FIRST;
					n.pend_fourth = 1'b0;
				end
			end
			ST_EMIT: begin
				if (wr_fire) begin
					if (wr_last) begin
						n.state = ST_IDLE;
						n.seq = r.seq + 14'h0001;
					end else begin
						n.idx = r.idx + 5'h01;
					end
				end
			end
		endcase
		// First time of a waiting event is kept; later repeats merge into it
		if (third_event_i) begin
			if (!n.pend_third) begin
				n.stamp_third = {time_seconds_i, time_fraction_i};
			end
			n.pend_third = 1'b1;
		end
		if (fourth_event_i) begin
			if (!n.pend_fourth) begin
				n.stamp_fourth = {time_seconds_i, time_fraction_i};
			end
			n.pend_fourth = 1'b1;
		end
		n.busy = (n.state == ST_EMIT) || n.pend_third || n.pend_fourth;
	end

	// State register
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	// ********************************************************
	// Output buffer
	// ********************************************************
	// A stalled sink fills the FIFO and then holds the builder on its current byte
	meep_fifo #(
		.WIDTH(FIFO_WIDTH),
		.DEPTH(FIFO_DEPTH)
	) meep_fifo_i (
		.clk_sys_i(clk_sys_i),
		.reset_i(reset_i),
		.in_valid_i(wr_valid),
		.in_data_i({wr_last, wr_byte}),
		.in_ready_o(wr_ready),
		.out_valid_o(fifo_valid),
		.out_data_o(fifo_out),
		.out_ready_i(out_ready_i)
	);

	// Outputs straight from FIFO and state flops
	assign out_data_o = fifo_out[7:0];
	assign out_last_o = fifo_out[8];
	assign out_valid_o = fifo_valid;
	assign busy_o = r.busy;
	assign source_sequence_count_field_o = r.seq;

	// ********************************************************
	// Checks
	// ********************************************************
	property p_first_byte;
		@(posedge clk_sys_i) disable iff (reset_i)
		wr_fire && r.idx == IDX_FIRST |-> wr_byte == 8'h0c;
	endproperty
	a_first_byte: assert property (p_first_byte)
		else $error("first header byte wrong");

	property p_ident_low;
		@(posedge clk_sys_i) disable iff (reset_i)
		wr_fire && r.idx == IDX_ID_LO |-> wr_byte == 8'h77;
	endproperty
	a_ident_low: assert property (p_ident_low)
		else $error("identifier and category byte wrong");

	property p_seq_field;
		@(posedge clk_sys_i) disable iff (reset_i)
		wr_fire && r.idx == IDX_SEQ_HI |-> wr_byte == {2'h3, r.seq[13:8]};
	endproperty
	a_seq_field: assert property (p_seq_field)
		else $error("segmentation flags or count high bits wrong");

	property p_seq_step;
		@(posedge clk_sys_i) disable iff (reset_i)
		wr_fire && wr_last |=> r.seq == $past(r.seq) + 14'h0001 && r.state == ST_IDLE;
	endproperty
	a_seq_step: assert property (p_seq_step)
		else $error("sequence count did not step by one");

	// Both length bytes are judged when they are written, so a stall cannot skip one
	property p_length;
		@(posedge clk_sys_i) disable iff (reset_i)
		wr_fire && (r.idx == IDX_LEN_HI || r.idx == IDX_LEN_LO)
			|-> wr_byte == ((r.idx == IDX_LEN_HI) ? 8'h00 : 8'h0b);
	endproperty
	a_length: assert property (p_length)
		else $error("packet length field is not 11");

	property p_time;
		@(posedge clk_sys_i) disable iff (reset_i)
		wr_fire && r.idx == IDX_TIME_FIRST |-> wr_byte == r.stamp[47:40];
	endproperty
	a_time: assert property (p_time)
		else $error("time stamp seconds byte wrong");

	property p_time_last;
		@(posedge clk_sys_i) disable iff (reset_i)
		wr_fire && r.idx == IDX_TIME_LAST |-> wr_byte == r.stamp[7:0];
	endproperty
	a_time_last: assert property (p_time_last)
		else $error("time stamp fraction byte wrong");

	property p_service_version;
		@(posedge clk_sys_i) disable iff (reset_i)
		wr_fire && r.idx == IDX_SVC_VER |-> wr_byte == 8'h40;
	endproperty
	a_service_version: assert property (p_service_version)
		else $error("service version byte wrong");

	property p_service_type;
		@(posedge clk_sys_i) disable iff (reset_i)
		wr_fire && r.idx == IDX_SVC_TYPE |-> wr_byte == 8'h05;
	endproperty
	a_service_type: assert property (p_service_type)
		else $error("service type is not event report");

	property p_third_id;
		@(posedge clk_sys_i) disable iff (reset_i)
		wr_fire && r.kind == KIND_THIRD && (r.idx == IDX_EID_HI || r.idx == IDX_LAST)
			|-> wr_byte == ((r.idx == IDX_EID_HI) ? 8'ha7 : 8'hfb);
	endproperty
	a_third_id: assert property (p_third_id)
		else $error("third kind event identifier wrong");

	property p_third_sub;
		@(posedge clk_sys_i) disable iff (reset_i)
		wr_fire && r.kind == KIND_THIRD && r.idx == IDX_SVC_SUB |-> wr_byte == 8'h02;
	endproperty
	a_third_sub: assert property (p_third_sub)
		else $error("third kind subtype is not warning");

	property p_fourth_start;
		@(posedge clk_sys_i) disable iff (reset_i)
		fourth_event_i && !third_event_i && !r.pend_third && r.state == ST_IDLE
			|=> ##1 r.state == ST_EMIT && r.kind == KIND_FOURTH;
	endproperty
	a_fourth_start: assert property (p_fourth_start)
		else $error("fourth kind packet did not start");

	property p_fourth_sub;
		@(posedge clk_sys_i) disable iff (reset_i)
		wr_fire && r.kind == KIND_FOURTH && r.idx == IDX_SVC_SUB |-> wr_byte == 8'h03;
	endproperty
	a_fourth_sub: assert property (p_fourth_sub)
		else $error("fourth kind subtype is not ground action");

	property p_source_len;
		@(posedge clk_sys_i) disable iff (reset_i)
		wr_fire && r.idx == IDX_PAD |-> wr_byte == 8'h00 && !wr_last;
	endproperty
	a_source_len: assert property (p_source_len)
		else $error("pad byte wrong or packet ended early");

	property p_fourth_id;
		@(posedge clk_sys_i) disable iff (reset_i)
		wr_fire && r.kind == KIND_FOURTH && (r.idx == IDX_EID_HI || r.idx == IDX_LAST)
			|-> wr_byte == ((r.idx == IDX_EID_HI) ? 8'ha7 : 8'hfc);
	endproperty
	a_fourth_id: assert property (p_fourth_id)
		else $error("fourth kind event identifier wrong");

	property p_no_gap;
		@(posedge clk_sys_i) disable iff (reset_i)
		wr_fire && !wr_last |=> r.state == ST_EMIT && r.idx == $past(r.idx) + 5'h01;
	endproperty
	a_no_gap: assert property (p_no_gap)
		else $error("byte index skipped or repeated");

	property p_hold;
		@(posedge clk_sys_i) disable iff (reset_i)
		wr_valid && !wr_ready |=> wr_valid && $stable(wr_byte);
	endproperty
	a_hold: assert property (p_hold)
		else $error("byte changed while stalled");

	// Main scenarios
	c_third_done: cover property (@(posedge clk_sys_i) wr_fire && wr_last && r.kind == KIND_THIRD);
	c_fourth_done: cover property (@(posedge clk_sys_i) wr_fire && wr_last && r.kind == KIND_FOURTH);
	c_stall: cover property (@(posedge clk_sys_i) wr_valid && !wr_ready);
	c_both: cover property (@(posedge clk_sys_i) third_event_i && fourth_event_i);

endmodule
`default_nettype wire

// *** logic/meep_pkg.sv ***
// Purpose: Shared constants and types for the mirror error event packet builder
// Assumes: One 50 MHz system clock, packets leave as a byte stream
// Notes: Byte positions index the 18-byte packet from its first byte
package meep_pkg;

	// ********************************************************
	// Clock and buffering
	// ********************************************************
	localparam int CLK_PERIOD_NS = 20;
	localparam int FIFO_WIDTH = 9;
	localparam int FIFO_DEPTH = 8;

	// ********************************************************
	// Primary header field values
	// ********************************************************
	localparam logic [2:0] VERSION_VAL = 3'h0;
	localparam logic TYPE_VAL = 1'h0;
	localparam logic DFH_FLAG_VAL = 1'h1;
	localparam logic [6:0] APPLICATION_PROCESS_IDENTIFIER = 7'h47;
	localparam logic [3:0] CATEGORY_VAL = 4'h7;
	localparam logic [1:0] SEGMENT_FLAGS_VAL = 2'h3;
	localparam logic [13:0] SEQ_RESET_VAL = 14'h0000;
	localparam logic [15:0] SOURCE_DATA_BYTES = 16'h0002;
	localparam logic [15:0] LENGTH_OFFSET = 16'h0009;

	// ********************************************************
	// Secondary header and source data values
	// ********************************************************
	localparam logic [2:0] SERVICE_VERSION_VAL = 3'h2;
	localparam logic CHECKSUM_FLAG_VAL = 1'h0;
	localparam logic [3:0] SPARE_VAL = 4'h0;
	localparam logic [7:0] SERVICE_TYPE_EVENT = 8'h05;
	localparam logic [7:0] SUBTYPE_WARNING = 8'h02;
	localparam logic [7:0] SUBTYPE_GROUND_ACTION = 8'h03;
	localparam logic [7:0] PAD_BYTE_VAL = 8'h00;
	localparam logic [15:0] EVENT_ID_THIRD = 16'ha7fb;
	localparam logic [15:0] EVENT_ID_FOURTH = 16'ha7fc;

	// ********************************************************
	// Byte positions inside a packet
	// ********************************************************
	localparam logic [4:0] IDX_FIRST = 5'h00;
	localparam logic [4:0] IDX_ID_LO = 5'h01;
	localparam logic [4:0] IDX_SEQ_HI = 5'h02;
	localparam logic [4:0] IDX_SEQ_LO = 5'h03;
	localparam logic [4:0] IDX_LEN_HI = 5'h04;
	localparam logic [4:0] IDX_LEN_LO = 5'h05;
	localparam logic [4:0] IDX_TIME_FIRST = 5'h06;
	localparam logic [4:0] IDX_TIME_LAST = 5'h0b;
	localparam logic [4:0] IDX_SVC_VER = 5'h0c;
	localparam logic [4:0] IDX_SVC_TYPE = 5'h0d;
	localparam logic [4:0] IDX_SVC_SUB = 5'h0e;
	localparam logic [4:0] IDX_PAD = 5'h0f;
	localparam logic [4:0] IDX_EID_HI = 5'h10;
	localparam logic [4:0] IDX_LAST = 5'h11;

	typedef enum logic {KIND_THIRD, KIND_FOURTH} meep_kind_type;
	typedef enum logic {ST_IDLE, ST_EMIT} meep_state_type;

endpackage

// *** logic/meep_fifo.sv ***
// Purpose: Byte FIFO with a registered output stage between builder and sink
// Assumes: Single clock, asynchronous active-high reset
// Notes: Holds DEPTH words in memory plus one in the output register
`timescale 1ns/1ps
`default_nettype none
module meep_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 8
) (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic in_valid_i,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic in_ready_o,
	output logic out_valid_o,
	output logic [WIDTH-1:0] out_data_o,
	input wire logic out_ready_i
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wr_ptr;
		logic [AW-1:0] rd_ptr;
		logic [CW-1:0] count;
		logic out_valid;
		logic [WIDTH-1:0] out_data;
	} meep_fifo_state_type;

	meep_fifo_state_type r, n;
	logic push;
	logic load;

	// ********************************************************
	// Next state
	// ********************************************************
	// Full is taken from the registered count so ready never depends on the sink
	always_comb begin
		n = r;
		in_ready_o = (r.count != CW'(DEPTH));
		push = in_valid_i && in_ready_o;
		load = (r.count != '0) && (!r.out_valid || out_ready_i);
		if (push) begin
			n.mem[r.wr_ptr] = in_data_i;
			n.wr_ptr = (r.wr_ptr == AW'(DEPTH - 1)) ? '0 : r.wr_ptr + AW'(1);
		end
		if (load) begin
			n.out_valid = 1'b1;
			n.out_data = r.mem[r.rd_ptr];
			n.rd_ptr = (r.rd_ptr == AW'(DEPTH - 1)) ? '0 : r.rd_ptr + AW'(1);
		end else if (r.out_valid && out_ready_i) begin
			n.out_valid = 1'b0;
		end
		n.count = r.count + CW'(push) - CW'(load);
		out_valid_o = r.out_valid;
		out_data_o = r.out_data;
	end

	// State register
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

endmodule
`default_nettype wire

// *** tb/meep_sink.sv ***
// Purpose: Telemetry sink model that takes packet bytes from the builder
// Assumes: Ready is the only signal this side drives; bytes count on valid and ready
// Notes: The slow mode accepts one byte in four to stress the builder's output buffer
`timescale 1ns/1ps
`default_nettype none
module meep_sink (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic slow_i,
	input wire logic valid_i,
	input wire logic [7:0] data_i,
	input wire logic last_i,
	output logic ready_o
);
	// Every accepted byte with its last flag, oldest first
	logic [8:0] got[$];
	logic [1:0] phase_r;

	// ********************************************************
	// Ready pattern
	// ********************************************************
	// Ready changes only just after an edge, never while a byte is sampled
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			phase_r <= 2'h0;
			ready_o <= 1'b0;
		end else begin
			phase_r <= phase_r + 2'h1;
			ready_o <= slow_i ? (phase_r == 2'h3) : 1'b1;
		end
	end

	// ********************************************************
	// Capture
	// ********************************************************
	// Reads the ready value that stood before this edge
	always @(posedge clk_sys_i) begin
		if (!reset_i && valid_i && ready_o) begin
			got.push_back({last_i, data_i});
		end
	end
endmodule
`default_nettype wire

// *** tb/meep_builder_tb.sv ***
// Purpose: Self-checking bench for the mirror error event packet builder
// Assumes: Inputs change at the falling edge; sink model drives ready
// Notes: Expected bytes are built here from the field layout, not from the design
`timescale 1ns/1ps
`default_nettype none
module meep_builder_tb;
	logic clk_sys_i;
	logic reset_i;
	logic third_event_i;
	logic fourth_event_i;
	logic [31:0] time_seconds_i;
	logic [15:0] time_fraction_i;
	logic [7:0] out_data_o;
	logic out_last_o;
	logic out_valid_o;
	logic out_ready_i;
	logic busy_o;
	logic [13:0] source_sequence_count_field_o;
	logic slow;
	int err_count;
	int checked;
	int cycles;
	int base;

	meep_builder meep_builder_i (
		.clk_sys_i(clk_sys_i),
		.reset_i(reset_i),
		.third_event_i(third_event_i),
		.fourth_event_i(fourth_event_i),
		.time_seconds_i(time_seconds_i),
		.time_fraction_i(time_fraction_i),
		.out_data_o(out_data_o),
		.out_last_o(out_last_o),
		.out_valid_o(out_valid_o),
		.out_ready_i(out_ready_i),
		.busy_o(busy_o),
		.source_sequence_count_field_o(source_sequence_count_field_o)
	);

	meep_sink meep_sink_i (
		.clk_sys_i(clk_sys_i),
		.reset_i(reset_i),
		.slow_i(slow),
		.valid_i(out_valid_o),
		.data_i(out_data_o),
		.last_i(out_last_o),
		.ready_o(out_ready_i)
	);

	// ********************************************************
	// Clock and hang guard
	// ********************************************************
	initial begin
		clk_sys_i = 1'b0;
		forever #10 clk_sys_i = ~clk_sys_i;
	end

	// Longest run is a few hundred cycles; the ceiling leaves ample margin
	always @(posedge clk_sys_i) begin
		cycles <= cycles + 1;
		if (cycles == 6000) begin
			err_count++;
			tally_and_finish();
		end
	end

	// ********************************************************
	// Compare and report
	// ********************************************************
	task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic check_bit(input logic got, input logic exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic check_seq(input logic [13:0] got, input logic [13:0] exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic tally_and_finish();
		if (err_count == 0 && checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// ********************************************************
	// Stimulus helpers
	// ********************************************************
	// Expected byte i of a packet; kind 1 is the fourth-kind report
	function automatic logic [7:0] exp_byte(int i, logic k, logic [13:0] q, logic [47:0] t);
		case (i)
			0: return 8'h0c;
			1: return 8'h77;
			2: return {2'h3, q[13:8]};
			3: return q[7:0];
			4: return 8'h00;
			5: return 8'h0b;
			12: return 8'h40;
			13: return 8'h05;
			14: return k ? 8'h03 : 8'h02;
			15: return 8'h00;
			16: return 8'ha7;
			17: return k ? 8'hfc : 8'hfb;
			default: return t[95 - 8 * i -: 8];
		endcase
	endfunction

	// One-cycle request pulse with its acquisition time
	task automatic send_event(input logic t3, input logic t4, input logic [47:0] t);
		@(negedge clk_sys_i);
		third_event_i = t3;
		fourth_event_i = t4;
		{time_seconds_i, time_fraction_i} = t;
		@(negedge clk_sys_i);
		third_event_i = 1'b0;
		fourth_event_i = 1'b0;
		time_seconds_i = ~time_seconds_i;
		time_fraction_i = ~time_fraction_i;
	endtask

	// Waits for one whole packet at the sink and compares every byte
	task automatic expect_packet(input logic k, input logic [13:0] q, input logic [47:0] t);
		int n;
		n = 0;
		while (meep_sink_i.got.size() < base + 18 && n < 800) begin
			@(negedge clk_sys_i);
			n++;
		end
		check_bit(meep_sink_i.got.size() >= base + 18, 1'b1);
		if (meep_sink_i.got.size() >= base + 18) begin
			for (int i = 0; i < 18; i++) begin
				check_byte(meep_sink_i.got[base + i][7:0], exp_byte(i, k, q, t));
				check_bit(meep_sink_i.got[base + i][8], i == 17);
			end
		end
		base += 18;
	endtask

	// ********************************************************
	// Scenarios
	// ********************************************************
	// Third-kind packet to a prompt sink, first packet after reset
	task automatic sc_third_prompt();
		slow = 1'b0;
		send_event(1'b1, 1'b0, 48'h0011_2233_4455);
		check_bit(busy_o, 1'b1);
		expect_packet(1'b0, 14'h0000, 48'h0011_2233_4455);
		repeat (4) @(negedge clk_sys_i);
		check_seq(source_sequence_count_field_o, 14'h0001);
	endtask

	// Fourth-kind packet while the sink stalls three cycles in four
	task automatic sc_fourth_stalled();
		slow = 1'b1;
		send_event(1'b0, 1'b1, 48'hfedc_ba98_7654);
		expect_packet(1'b1, 14'h0001, 48'hfedc_ba98_7654);
		slow = 1'b0;
	endtask

	// Both requests together; the time goes to both and counts rise back to back
	task automatic sc_both_together();
		send_event(1'b1, 1'b1, 48'h8000_0001_ffff);
		expect_packet(1'b0, 14'h0002, 48'h8000_0001_ffff);
		expect_packet(1'b1, 14'h0003, 48'h8000_0001_ffff);
	endtask

	// A repeated request while one waits behind a running packet gives a single packet
	task automatic sc_merge();
		send_event(1'b0, 1'b1, 48'h0102_0304_0506);
		send_event(1'b1, 1'b0, 48'h1234_5678_9abc);
		send_event(1'b1, 1'b0, 48'h0000_0000_0001);
		expect_packet(1'b1, 14'h0004, 48'h0102_0304_0506);
		expect_packet(1'b0, 14'h0005, 48'h1234_5678_9abc);
		repeat (60) @(negedge clk_sys_i);
		check_seq(14'(meep_sink_i.got.size()), 14'(base));
		check_bit(busy_o, 1'b0);
	endtask

	// Reset in mid-run returns the count to zero
	task automatic sc_reset_count();
		reset_i = 1'b1;
		@(negedge clk_sys_i);
		reset_i = 1'b0;
		check_seq(source_sequence_count_field_o, 14'h0000);
		send_event(1'b0, 1'b1, 48'h0a0b_0c0d_0e0f);
		expect_packet(1'b1, 14'h0000, 48'h0a0b_0c0d_0e0f);
	endtask

	// ********************************************************
	// Main sequence
	// ********************************************************
	initial begin
		reset_i = 1'b1;
		third_event_i = 1'b0;
		fourth_event_i = 1'b0;
		time_seconds_i = 32'h0000_0000;
		time_fraction_i = 16'h0000;
		slow = 1'b0;
		err_count = 0;
		checked = 0;
		cycles = 0;
		base = 0;
		repeat (2) @(negedge clk_sys_i);
		reset_i = 1'b0;
		sc_third_prompt();
		sc_fourth_stalled();
		sc_both_together();
		sc_merge();
		sc_reset_count();
		tally_and_finish();
	end
endmodule
`default_nettype wire
